// [hw/sfps_pkg.sv]
// Shared constants, command codes and carriers for the flash sector host
package sfps_pkg;
    localparam int CLK_MHZ = 250;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int SECT_BYTES = 128;
    localparam int BIDX_W = 7;
    localparam int SECTOR_W = 9;
    localparam int PREAMBLE_LEN = 3;
    localparam int ERASE_LEN = 6;
    localparam int PROG_LEN = PREAMBLE_LEN + SECT_BYTES;
    localparam int TOGGLE_BIT = 6;
    localparam int POLL_BIT = 7;
    // Times in their own units, cycle counts derived from the clock rate
    localparam int WE_LOW_NS = 100;
    localparam int WE_HIGH_NS = 100;
    localparam int READ_NS = 250;
    localparam int LOAD_GAP_US = 150;
    localparam int POWER_WAIT_MS = 20;
    localparam int WRITE_CYCLE_MS = 20;
    localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int LOAD_GAP_CYC = LOAD_GAP_US * CLK_MHZ;
    localparam int POWER_WAIT_CYC = POWER_WAIT_MS * CLK_MHZ * 1000;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * CLK_MHZ * 1000;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_BUF = 8'h0c;
    localparam int BUF_IDX_LSB = 8;
    localparam int STAT_RDATA_LSB = 8;
    // Operation codes written to the control register
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_PROG = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;

    typedef struct packed {
        logic start;
        logic [1:0] op;
        logic [ADDR_W-1:0] addr;
    } sfps_cmd_s;

    typedef struct packed {
        logic busy;
        logic ready;
        logic done;
        logic timeout;
        logic [DATA_W-1:0] rd_byte;
    } sfps_stat_s;

    typedef struct packed {
        logic we;
        logic [BIDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } sfps_buf_wr_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_select_n;
        logic output_drive_enable_n;
        logic write_strobe_n;
        logic [DATA_W-1:0] data_out;
        logic data_drive_n;
    } sfps_pins_s;
endpackage : sfps_pkg

// [hw/sfps_ahb_regs.sv]
// AHB-Lite register slave for the flash sector host
`timescale 1ns/1ns
module sfps_ahb_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire sfps_pkg::sfps_stat_s stat,
    output sfps_pkg::sfps_cmd_s cmd,
    output sfps_pkg::sfps_buf_wr_s buf_wr
);
    import sfps_pkg::*;

    logic wr_pend;
    logic [7:0] wr_addr;
    logic [ADDR_W-1:0] addr_reg;
    logic [31:0] status_word;
    logic addr_phase;

    // Zero wait state: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel && hready && htrans[1];
    // A start just written shows as busy before the sequencer takes it
    assign status_word = {16'h0000, stat.rd_byte, 4'h0, stat.timeout,
                          stat.done, stat.ready, stat.busy | cmd.start};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite && (hsize == 3'h2);
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                REG_CTRL: hrdata <= {30'h0000_0000, cmd.op};
                REG_ADDR: hrdata <= {16'h0000, addr_reg};
                REG_STATUS: hrdata <= status_word;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd <= '0;
            addr_reg <= '0;
        end else begin
            cmd.start <= wr_pend && (wr_addr == REG_CTRL)
                         && (hwdata[1:0] != OP_NONE);
            if (wr_pend && wr_addr == REG_CTRL) begin
                cmd.op <= hwdata[1:0];
            end
            if (wr_pend && wr_addr == REG_ADDR) begin
                addr_reg <= hwdata[ADDR_W-1:0];
            end
            cmd.addr <= addr_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_wr <= '0;
        end else begin
            buf_wr.we <= wr_pend && (wr_addr == REG_BUF);
            buf_wr.idx <= hwdata[BUF_IDX_LSB +: BIDX_W];
            buf_wr.data <= hwdata[DATA_W-1:0];
        end
    end
endmodule : sfps_ahb_regs

// [hw/sfps_host.sv]
// Host-side sequencer that reads, programs and erases the sector flash
`timescale 1ns/1ns
module sfps_host #(
    parameter int POWER_WAIT = sfps_pkg::POWER_WAIT_CYC,
    parameter int WRITE_CYCLE = sfps_pkg::WRITE_CYCLE_CYC,
    parameter int LOAD_GAP = sfps_pkg::LOAD_GAP_CYC,
    parameter logic [3*16-1:0] PROG_SEQ_ADDR = 48'h0003_0002_0001,
    parameter logic [3*8-1:0] PROG_SEQ_DATA = 24'h03_02_01,
    parameter logic [6*16-1:0] ERASE_SEQ_ADDR =
        96'h0006_0005_0004_0003_0002_0001,
    parameter logic [6*8-1:0] ERASE_SEQ_DATA = 48'h16_15_14_13_12_11
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output sfps_pkg::sfps_pins_s pins,
    input wire logic [sfps_pkg::DATA_W-1:0] data_in
);
    import sfps_pkg::*;

    typedef enum logic [7:0] {
        S_PWR = 8'h01,
        S_IDLE = 8'h02,
        S_RD = 8'h04,
        S_WLO = 8'h08,
        S_WHI = 8'h10,
        S_POLL = 8'h20,
        S_PGAP = 8'h40
    } sfps_state_e;

    sfps_state_e state;
    sfps_state_e next_state;
    sfps_cmd_s cmd;
    sfps_stat_s stat;
    sfps_buf_wr_s buf_wr;
    logic [DATA_W-1:0] sect_buf [SECT_BYTES];
    logic [1:0] op;
    logic [ADDR_W-1:0] tgt_addr;
    logic [7:0] step;
    logic [7:0] next_step;
    logic [7:0] last_step;
    logic [31:0] cnt;
    logic [31:0] pwr_cnt;
    logic [31:0] poll_tmr;
    logic [1:0] polls;
    logic prev_tog;
    logic poll_ok;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_data;
    logic [BIDX_W-1:0] bidx;
    logic [DATA_W-1:0] last_data;
    logic [ADDR_W-1:0] poll_addr;
    logic phase_end;
    logic [1:0] use_op;

    sfps_ahb_regs u_regs (
        .clk(clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .stat(stat),
        .cmd(cmd),
        .buf_wr(buf_wr)
    );

    // Sector image; bytes never written stay as whatever software left
    always_ff @(posedge clk) begin
        if (buf_wr.we) begin
            sect_buf[buf_wr.idx] <= buf_wr.data;
        end
    end

    assign last_step = (op == OP_PROG) ? 8'(PROG_LEN - 1) : 8'(ERASE_LEN - 1);
    assign last_data = sect_buf[SECT_BYTES-1];
    assign poll_addr = {tgt_addr[ADDR_W-1:BIDX_W], {BIDX_W{1'b1}}};
    // First stroke leaves idle before op is loaded, so use the new op
    assign use_op = (state == S_IDLE) ? cmd.op : op;

    always_comb begin
        case (state)
            S_RD, S_POLL: phase_end = (cnt == 32'(READ_CYC - 1));
            S_WLO: phase_end = (cnt == 32'(WE_LOW_CYC - 1));
            S_WHI: phase_end = (cnt == 32'(WE_HIGH_CYC - 1));
            default: phase_end = 1'b1;
        endcase
    end

    // Done on stable toggle bit, plus true last byte when programming
    assign poll_ok = (polls == 2'h2) && (stat.rd_byte[TOGGLE_BIT] == prev_tog)
                     && (op != OP_PROG || stat.rd_byte == last_data);

    always_comb begin
        next_state = state;
        next_step = step;
        case (state)
            S_PWR: begin
                if (pwr_cnt == 32'(POWER_WAIT - 1)) begin
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (cmd.start) begin
                    next_step = 8'h00;
                    next_state = (cmd.op == OP_READ) ? S_RD : S_WLO;
                end
            end
            S_RD: begin
                if (phase_end) begin
                    next_state = S_IDLE;
                end
            end
            S_WLO: begin
                if (phase_end) begin
                    next_state = S_WHI;
                end
            end
            S_WHI: begin
                if (phase_end) begin
                    if (step == last_step) begin
                        next_state = S_POLL;
                    end else begin
                        next_step = step + 8'h01;
                        next_state = S_WLO;
                    end
                end
            end
            S_POLL: begin
                if (phase_end) begin
                    next_state = S_PGAP;
                end
            end
            S_PGAP: begin
                if (poll_ok || poll_tmr >= 32'(WRITE_CYCLE)) begin
                    next_state = S_IDLE;
                end else begin
                    next_state = S_POLL;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    // Address and data of the write step about to be presented
    always_comb begin
        bidx = BIDX_W'(next_step - 8'(PREAMBLE_LEN));
        if (use_op == OP_ERASE) begin
            next_addr = ERASE_SEQ_ADDR[next_step*16 +: 16];
            next_data = ERASE_SEQ_DATA[next_step*8 +: 8];
        end else if (next_step < 8'(PREAMBLE_LEN)) begin
            next_addr = PROG_SEQ_ADDR[next_step*16 +: 16];
            next_data = PROG_SEQ_DATA[next_step*8 +: 8];
        end else begin
            next_addr = {tgt_addr[ADDR_W-1:BIDX_W], bidx};
            next_data = sect_buf[bidx];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_PWR;
            step <= 8'h00;
            cnt <= 32'h0000_0000;
        end else begin
            state <= next_state;
            step <= next_step;
            cnt <= (next_state != state) ? 32'h0000_0000 : cnt + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op <= OP_NONE;
            tgt_addr <= '0;
        end else if (state == S_IDLE && cmd.start) begin
            op <= cmd.op;
            tgt_addr <= cmd.addr;
        end
    end

    // Power-up hold-off before the first access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_cnt <= 32'h0000_0000;
        end else if (state == S_PWR) begin
            pwr_cnt <= pwr_cnt + 32'h1;
        end
    end

    // Pins follow the state being entered, so every output is a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins.addr <= '0;
            pins.chip_select_n <= 1'b1;
            pins.output_drive_enable_n <= 1'b1;
            pins.write_strobe_n <= 1'b1;
            pins.data_out <= '0;
            pins.data_drive_n <= 1'b1;
        end else begin
            pins.chip_select_n <= !(next_state inside {S_RD, S_WLO, S_POLL});
            pins.output_drive_enable_n <= !(next_state inside {S_RD, S_POLL});
            pins.write_strobe_n <= (next_state != S_WLO);
            // Data held one phase past the strobe rise for device hold time
            pins.data_drive_n <= !(next_state inside {S_WLO, S_WHI});
            if (next_state == S_RD && state == S_IDLE) begin
                pins.addr <= cmd.addr;
            end else if (next_state == S_POLL) begin
                pins.addr <= (op == OP_PROG) ? poll_addr : tgt_addr;
            end else if (next_state == S_WLO) begin
                pins.addr <= next_addr;
                pins.data_out <= next_data;
            end
        end
    end

    // Polling reads the last loaded byte (the target address for erase) until it settles or WRITE_CYCLE runs out; one block
    // owns the status word so that it has a single driver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat <= '0;
            prev_tog <= 1'b0;
            polls <= 2'h0;
            poll_tmr <= 32'h0000_0000;
        end else begin
            stat.busy <= !(next_state inside {S_IDLE, S_PWR});
            stat.ready <= (next_state != S_PWR);
            if ((state == S_RD || state == S_POLL) && phase_end) begin
                stat.rd_byte <= data_in;
                prev_tog <= stat.rd_byte[TOGGLE_BIT];
                if (polls != 2'h2) begin
                    polls <= polls + 2'h1;
                end
            end
            if (state == S_IDLE) begin
                polls <= 2'h0;
                poll_tmr <= 32'h0000_0000;
            end else if (state == S_POLL || state == S_PGAP) begin
                poll_tmr <= poll_tmr + 32'h1;
            end
            if (state == S_IDLE && cmd.start) begin
                stat.done <= 1'b0;
                stat.timeout <= 1'b0;
            end else if (state == S_RD && phase_end) begin
                stat.done <= 1'b1;
            end else if (state == S_PGAP && next_state == S_IDLE) begin
                stat.done <= 1'b1;
                stat.timeout <= !poll_ok;
            end
        end
    end

    // Helper counts for the checks below
    logic [31:0] gap_cnt;
    logic [7:0] loads;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_cnt <= 32'h0000_0000;
            loads <= 8'h00;
        end else begin
            gap_cnt <= (state == S_WHI) ? gap_cnt + 32'h1 : 32'h0000_0000;
            if (state == S_IDLE) begin
                loads <= 8'h00;
            end else if ($fell(pins.write_strobe_n)) begin
                loads <= loads + 8'h01;
            end
        end
    end

    chk_oe_on_load: assert property (@(posedge clk) disable iff (rst)
        !pins.write_strobe_n |-> pins.output_drive_enable_n
            && !pins.chip_select_n)
        else $error("strobe low without select or with output enable");
    chk_no_contention: assert property (@(posedge clk) disable iff (rst)
        !pins.data_drive_n |-> pins.output_drive_enable_n)
        else $error("host drives data while device may drive");
    chk_load_gap: assert property (@(posedge clk) disable iff (rst)
        gap_cnt < 32'(LOAD_GAP))
        else $error("byte load gap too long");
    chk_sector_hold: assert property (@(posedge clk) disable iff (rst)
        $fell(pins.write_strobe_n) && op == OP_PROG
            && loads >= 8'(PREAMBLE_LEN)
        |-> pins.addr[ADDR_W-1:BIDX_W] == tgt_addr[ADDR_W-1:BIDX_W])
        else $error("sector address changed during load");
    chk_power_wait: assert property (@(posedge clk) disable iff (rst)
        state == S_PWR |-> pins.chip_select_n && pwr_cnt < 32'(POWER_WAIT))
        else $error("access before power-up wait");
    chk_preamble_first: assert property (@(posedge clk) disable iff (rst)
        $fell(pins.write_strobe_n) && op == OP_PROG && loads == 8'h00
        |-> pins.addr == PROG_SEQ_ADDR[15:0]
            && pins.data_out == PROG_SEQ_DATA[7:0])
        else $error("program did not open with the preamble");
    chk_full_sector: assert property (@(posedge clk) disable iff (rst)
        state == S_WHI && next_state == S_POLL && op == OP_PROG
        |-> loads == 8'(PROG_LEN))
        else $error("sector not fully loaded");
    chk_erase_len: assert property (@(posedge clk) disable iff (rst)
        state == S_WHI && next_state == S_POLL && op == OP_ERASE
        |-> loads == 8'(ERASE_LEN))
        else $error("erase sequence length wrong");
    chk_done_true: assert property (@(posedge clk) disable iff (rst)
        state == S_PGAP && poll_ok && op == OP_PROG
        |=> stat.done && !stat.timeout && stat.rd_byte == last_data)
        else $error("program reported done without true data");
endmodule : sfps_host

// [verification/sfps_flash_model.sv]
// Behavioural model of the sector flash as seen on its pins
`timescale 1ns/1ns
module sfps_flash_model #(
    parameter int GAP_NS = 2000,
    parameter int BUSY_NS = 4000,
    parameter int SLOW_NS = 20000,
    parameter int POWER_NS = 200,
    // Identity codes are arbitrary values for this model
    parameter logic [7:0] MAN_ID = 8'h5a,
    parameter logic [7:0] DEV_ID = 8'hc3
) (
    input wire logic [15:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] din,
    input wire logic slow,
    input wire logic id_pin,
    output logic [7:0] dout,
    output logic dout_en,
    output logic bad
);
    // No reset input: protection state survives like a power cycle
    logic [7:0] mem [0:65535];
    logic [7:0] img [0:127];
    logic [15:0] a_lat;
    logic [8:0] sect;
    logic [7:0] last_d = 8'hff;
    logic [2:0] pre = 3'h0;
    logic [2:0] ec = 3'h0;
    logic [1:0] kind = 2'h0;
    logic loading = 1'b0;
    logic busy = 1'b0;
    logic tog = 1'b0;
    time fall_t = 0;
    time rise_t = 0;
    time end_t = 0;
    wire stb = ce_n | we_n;
    wire rd = ce_n | oe_n;
    initial begin
        bad = 1'b0;
        for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
    end
    task automatic start(input logic [1:0] k);
        kind = k;
        busy = 1'b1;
        end_t = $time + (slow ? SLOW_NS : BUSY_NS);
    endtask : start
    task automatic take(input logic [15:0] a, input logic [7:0] d);
        logic m1;
        logic m2;
        m1 = a == 16'(pre) + 16'h1 && d == 8'(pre) + 8'h1;
        m2 = a == 16'(ec) + 16'h1 && d == 8'(ec) + 8'h11;
        if (loading) begin
            img[a[6:0]] = d;
            sect = a[15:7];
            last_d = d;
        end else begin
            pre = m1 ? pre + 3'h1 : 3'h0;
            ec = m2 ? ec + 3'h1 : 3'h0;
            if (pre == 3'h3) begin
                loading = 1'b1;
                pre = 3'h0;
                ec = 3'h0;
                for (int i = 0; i < 128; i++) img[i] = 8'hff;
            end else if (ec == 3'h6) begin
                ec = 3'h0;
                last_d = 8'hff;
                start(2'h2);
            end else if (!m1 && !m2) begin
                last_d = 8'hff;
                start(2'h0);
            end
        end
    endtask : take
    always @(negedge stb) begin
        fall_t = $time;
        // Address and strobe change in one step; let the address land
        #1;
        a_lat = addr;
        if (!oe_n) bad = 1'b1;
    end
    always @(posedge stb) begin
        rise_t = $time;
        // Short pulses, output enable low and early writes are ignored
        if (oe_n && !busy && $time - fall_t >= 15 && $time >= POWER_NS)
            take(a_lat, din);
    end
    always begin
        #100;
        if (loading && stb && $time - rise_t > GAP_NS) begin
            loading = 1'b0;
            start(2'h1);
        end
        if (busy && $time >= end_t) begin
            if (kind == 2'h2)
                for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
            if (kind == 2'h1)
                for (int i = 0; i < 128; i++)
                    mem[{sect, 7'(i)}] = img[i];
            busy = 1'b0;
        end
    end
    always @(negedge rd) if (busy) tog = ~tog;
    assign dout_en = !rd && we_n;
    // Identification pin stands for the raised-voltage address pin
    assign dout = busy ? {~last_d[7], tog, last_d[5:0]} :
        id_pin ? (addr[0] ? DEV_ID : MAN_ID) : mem[addr];
endmodule : sfps_flash_model

// [verification/testbench.sv]
// Self-checking bench for the flash sector host
`timescale 1ns/1ns
module testbench;
    import sfps_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    sfps_pins_s pins;
    logic [7:0] data_in;
    logic [7:0] last_bus = 8'h00;
    logic [7:0] dout;
    logic dout_en;
    logic bad;
    logic slow = 1'b0;
    logic id_hw = 1'b0;
    // Arbitrary identity codes, shared with the model
    localparam logic [7:0] MAN_ID = 8'h5a;
    localparam logic [7:0] DEV_ID = 8'hc3;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    sfps_host #(.POWER_WAIT(100), .WRITE_CYCLE(2000)) uut (.clk(clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pins(pins),
        .data_in(data_in));
    sfps_flash_model #(.MAN_ID(MAN_ID), .DEV_ID(DEV_ID)) flash (
        .addr(pins.addr), .ce_n(pins.chip_select_n),
        .oe_n(pins.output_drive_enable_n), .we_n(pins.write_strobe_n),
        .din(data_in), .slow(slow), .id_pin(id_hw), .dout(dout),
        .dout_en(dout_en), .bad(bad));
    // Undriven lines show the inverse of the last value, never a held one
    always @(posedge clk) last_bus <= data_in;
    assign data_in = !pins.data_drive_n ? pins.data_out :
        dout_en ? dout : ~last_bus;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic wait_done(output logic [31:0] r);
        for (int i = 0; i < 5000; i++) begin
            ahb(1'b0, REG_STATUS, 32'h0, r);
            if (r[2] === 1'b1) return;
        end
        chk(r[2], 1'b1);
    endtask : wait_done
    function automatic logic [7:0] pat(input int i, input logic [7:0] s);
        return 8'(i * 37) ^ s;
    endfunction : pat
    task automatic start_op(input logic [15:0] a, input logic [1:0] op,
        output logic [31:0] r);
        ahb(1'b1, REG_ADDR, {16'h0, a}, r);
        @(posedge clk);
        ahb(1'b1, REG_CTRL, {30'h0, op}, r);
        wait_done(r);
    endtask : start_op
    task automatic t_read(input logic [15:0] a, input logic [7:0] exp);
        logic [31:0] r;
        start_op(a, OP_READ, r);
        chk(r[15:8], exp);
    endtask : t_read
    task automatic t_power();
        logic [31:0] r;
        ahb(1'b0, REG_STATUS, 32'h0, r);
        chk(r[1:0], 2'b00);
        for (int i = 0; i < 200 && r[1] !== 1'b1; i++)
            ahb(1'b0, REG_STATUS, 32'h0, r);
        chk(r[3:0], 4'b0010);
        $display("test power done at %0t", $time);
    endtask : t_power
    // Every program loads a whole sector; readback of a passing one covers both ends
    task automatic t_program(input logic [8:0] s, input logic [7:0] seed,
        input logic [3:0] exp_stat);
        logic [31:0] r;
        for (int i = 0; i < 128; i++)
            ahb(1'b1, REG_BUF, {17'h0, 7'(i), pat(i, seed)}, r);
        start_op({s, 7'h0}, OP_PROG, r);
        chk(r[3:0], exp_stat);
        if (exp_stat == 4'b0110) begin
            t_read({s, 7'h00}, pat(0, seed));
            t_read({s, 7'h4d}, pat(77, seed));
            t_read({s, 7'h7f}, pat(127, seed));
        end
        $display("test program done at %0t", $time);
    endtask : t_program
    task automatic t_erase();
        logic [31:0] r;
        start_op(16'h0, OP_ERASE, r);
        chk(r[3:0], 4'b0110);
        t_read({9'h5, 7'h03}, 8'hff);
        $display("test erase done at %0t", $time);
    endtask : t_erase
    // Hardware identification: codes come back through the read path
    task automatic t_ident();
        id_hw <= 1'b1;
        t_read(16'h0000, MAN_ID);
        t_read(16'h0001, DEV_ID);
        id_hw <= 1'b0;
        $display("test ident done at %0t", $time);
    endtask : t_ident
    task automatic t_regs();
        logic [31:0] r;
        ahb(1'b0, 8'h10, 32'h0, r);
        chk(r, 32'h0);
        chk(hresp, 1'b0);
        chk(bad, 1'b0);
        $display("test regs done at %0t", $time);
    endtask : t_regs
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_power();
        t_program(9'h5, 8'h10, 4'b0110);
        // Second pass over the same sector, with no erase between, needs a new preamble
        t_program(9'h5, 8'h21, 4'b0110);
        t_erase();
        t_ident();
        slow <= 1'b1;
        t_program(9'h9, 8'h33, 4'b1110);
        t_regs();
        complete_run();
    end
endmodule : testbench
